// ==== pkg/hfs_consts.svh ====
// Contract
// - The low seven bits of the receive byte-count register give how many bytes, 0 to 64, the host may read.
// - The receive count never reaches past the end of a message.
// - The count's top bit reads 1 while the counted bytes belong to a message not yet ended.
// - A latched status bit goes to 1 on its event and stays 1 until the host writes 1 to it.
// - A cleared latched bit stays 0 until a fresh occurrence of its event.
// - Real-time status bits follow the present condition and writes leave them unchanged.
// - Status bits written as 0 stay untouched; only bits written as 1 are cleared.
// - Each latched receive and transmit event is individually maskable from the interrupt.
// - An unmasked event pulls the active-low interrupt low until no enabled event remains.
// - The transmit space register gives the bytes the host may write without overflow.
// - The transmit space count tracks in real time but is stable during a host read.
// - A receive overrun drops the packet, empties the FIFO and sets real-time and latched overrun.
// - Each direction's FIFO holds 64 bytes.
`ifndef HFS_CONSTS_SVH
`define HFS_CONSTS_SVH
`define HFS_DEPTH 7'h40
`define HFS_IDX_RX_RT 10'h0b4
`define HFS_IDX_RX_PBA 10'h0b5
`define HFS_IDX_RX_LAT 10'h094
`define HFS_IDX_RX_MASK 10'h0a4
`define HFS_IDX_RX_CLR 10'h0b7
`define HFS_IDX_TX_LAT 10'h191
`define HFS_IDX_TX_MASK 10'h1a1
`define HFS_IDX_TX_SPACE 10'h1b3
`define HFS_IDX_TX_CLR 10'h1b7
`define HFS_RX_EOM_BIT 0
`define HFS_RX_HWM_BIT 1
`define HFS_RX_OVR_BIT 5
`define HFS_TX_LWM_BIT 0
`define HFS_TX_EMPTY_BIT 1
`define HFS_MASK_RESET 8'h00
`define HFS_HTRANS_NONSEQ 2'h2
`endif

// ==== pkg/hfs_pkg.sv ====
package hfs_pkg;
	typedef struct packed {
		logic rx_push;
		logic rx_eom;
		logic rx_pop;
		logic tx_push;
		logic tx_pop;
	} hfs_ev_t;

	typedef struct packed {
		logic [63:0] rx_eom;
		logic [5:0] rx_wr;
		logic [5:0] rx_rd;
		logic [6:0] rx_lvl;
		logic rx_drop;
		logic rx_ovr_rt;
		logic rx_hwm_prev;
		logic [6:0] tx_lvl;
		logic tx_lwm_prev;
		logic tx_empty_prev;
		logic [7:0] rx_lat;
		logic [7:0] tx_lat;
		logic [7:0] rx_mask;
		logic [7:0] tx_mask;
		logic ph_wr;
		logic [9:0] ph_idx;
		logic [31:0] rdata;
		logic irq_n;
	} hfs_state_t;
endpackage

// ==== logic/hfs_status.sv ====
`timescale 1ns/1ps
`include "hfs_consts.svh"
module hfs_status #(
	parameter logic [6:0] RX_HWM = 7'h30,
	parameter logic [6:0] TX_LWM = 7'h10
) (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic hsel,
	input wire logic [11:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire hfs_pkg::hfs_ev_t ev,
	output logic [7:0] rx_packet_bytes_available,
	output logic [7:0] tx_fifo_space_count,
	output logic irq_out_n
);
	hfs_pkg::hfs_state_t s_r;
	hfs_pkg::hfs_state_t s_nxt;
	logic acc;
	logic wr_en;
	logic [7:0] wbyte;
	logic [7:0] rx_rt;
	logic [7:0] pba;
	logic [6:0] tx_space;
	logic rx_hwm;
	logic tx_lwm;
	logic tx_empty;
	logic rx_ovr_ev;

	// Bytes up to and including the first message end, or all with bit 7 set if any are held.
	function automatic logic [7:0] seg_count(input logic [63:0] eom,
		input logic [5:0] rd, input logic [6:0] lvl);
		logic found;
		logic [5:0] p;
		seg_count = {1'b0, lvl};
		found = 1'b0;
		for (int i = 0; i < 64; i++) begin
			p = rd + 6'(i);
			if (!found && 7'(i) < lvl && eom[p]) begin
				found = 1'b1;
				seg_count = {1'b0, 7'(i + 1)};
			end
		end
		if (!found && lvl != 7'h00) begin
			seg_count[7] = 1'b1;
		end
	endfunction

	assign acc = hsel && hready && htrans == `HFS_HTRANS_NONSEQ;
	assign wr_en = s_r.ph_wr;
	assign wbyte = hwdata[7:0];
	assign rx_hwm = s_r.rx_lvl >= RX_HWM;
	assign tx_lwm = s_r.tx_lvl < TX_LWM;
	assign tx_empty = s_r.tx_lvl == 7'h00;
	assign tx_space = `HFS_DEPTH - s_r.tx_lvl;
	assign pba = seg_count(s_r.rx_eom, s_r.rx_rd, s_r.rx_lvl);
	assign rx_ovr_ev = ev.rx_push && !s_r.rx_drop && s_r.rx_lvl == `HFS_DEPTH;

	always_comb begin
		rx_rt = 8'h00;
		rx_rt[`HFS_RX_EOM_BIT] = s_r.rx_lvl != 7'h00;
		rx_rt[`HFS_RX_HWM_BIT] = rx_hwm;
		rx_rt[`HFS_RX_OVR_BIT] = s_r.rx_ovr_rt;
	end

	always_comb begin
		logic [7:0] rx_set;
		logic [7:0] tx_set;
		logic [7:0] rx_clr;
		logic [7:0] tx_clr;
		logic push_ok;
		logic pop_ok;
		rx_set = 8'h00;
		tx_set = 8'h00;
		rx_clr = 8'h00;
		tx_clr = 8'h00;
		push_ok = 1'b0;
		pop_ok = 1'b0;
		s_nxt = s_r;
		// Receive FIFO bookkeeping.
		pop_ok = ev.rx_pop && s_r.rx_lvl != 7'h00;
		push_ok = ev.rx_push && !s_r.rx_drop && !rx_ovr_ev;
		if (rx_ovr_ev) begin
			s_nxt.rx_wr = 6'h00;
			s_nxt.rx_rd = 6'h00;
			s_nxt.rx_lvl = 7'h00;
			s_nxt.rx_eom = 64'h0;
			s_nxt.rx_drop = !ev.rx_eom;
			s_nxt.rx_ovr_rt = 1'b1;
			rx_set[`HFS_RX_OVR_BIT] = 1'b1;
		end else begin
			if (ev.rx_push && s_r.rx_drop && ev.rx_eom) begin
				s_nxt.rx_drop = 1'b0;
			end
			if (push_ok) begin
				s_nxt.rx_eom[s_r.rx_wr] = ev.rx_eom;
				s_nxt.rx_wr = s_r.rx_wr + 6'h01;
				s_nxt.rx_ovr_rt = 1'b0;
				if (ev.rx_eom) begin
					rx_set[`HFS_RX_EOM_BIT] = 1'b1;
				end
			end
			if (pop_ok) begin
				s_nxt.rx_rd = s_r.rx_rd + 6'h01;
			end
			s_nxt.rx_lvl = s_r.rx_lvl + 7'(push_ok) - 7'(pop_ok);
		end
		// Transmit level; pushes beyond the depth are refused.
		push_ok = ev.tx_push && s_r.tx_lvl != `HFS_DEPTH;
		pop_ok = ev.tx_pop && s_r.tx_lvl != 7'h00;
		s_nxt.tx_lvl = s_r.tx_lvl + 7'(push_ok) - 7'(pop_ok);
		// Events are edges of the conditions, so a clear is not undone.
		s_nxt.rx_hwm_prev = rx_hwm;
		s_nxt.tx_lwm_prev = tx_lwm;
		s_nxt.tx_empty_prev = tx_empty;
		rx_set[`HFS_RX_HWM_BIT] = rx_hwm && !s_r.rx_hwm_prev;
		tx_set[`HFS_TX_LWM_BIT] = tx_lwm && !s_r.tx_lwm_prev;
		tx_set[`HFS_TX_EMPTY_BIT] = tx_empty && !s_r.tx_empty_prev;
		// Register writes in the data phase.
		if (wr_en) begin
			case (s_r.ph_idx)
				`HFS_IDX_RX_LAT, `HFS_IDX_RX_CLR: begin
					rx_clr = wbyte;
				end
				`HFS_IDX_TX_LAT, `HFS_IDX_TX_CLR: begin
					tx_clr = wbyte;
				end
				`HFS_IDX_RX_MASK: begin
					s_nxt.rx_mask = wbyte;
				end
				`HFS_IDX_TX_MASK: begin
					s_nxt.tx_mask = wbyte;
				end
				default: begin
				end
			endcase
		end
		// A new event wins over a clear in the same cycle.
		s_nxt.rx_lat = (s_r.rx_lat & ~rx_clr) | rx_set;
		s_nxt.tx_lat = (s_r.tx_lat & ~tx_clr) | tx_set;
		s_nxt.irq_n = ~|((s_nxt.rx_lat & s_r.rx_mask)
			| (s_nxt.tx_lat & s_r.tx_mask));
		// Address phase: latch the write, or sample read data now.
		s_nxt.ph_wr = acc && hwrite;
		s_nxt.ph_idx = haddr[11:2];
		if (acc && !hwrite) begin
			case (haddr[11:2])
				`HFS_IDX_RX_RT: s_nxt.rdata = {24'h0, rx_rt};
				`HFS_IDX_RX_PBA: s_nxt.rdata = {24'h0, pba};
				`HFS_IDX_RX_LAT: s_nxt.rdata = {24'h0, s_r.rx_lat};
				`HFS_IDX_RX_MASK: s_nxt.rdata = {24'h0, s_r.rx_mask};
				`HFS_IDX_TX_LAT: s_nxt.rdata = {24'h0, s_r.tx_lat};
				`HFS_IDX_TX_MASK: s_nxt.rdata = {24'h0, s_r.tx_mask};
				`HFS_IDX_TX_SPACE: s_nxt.rdata = {25'h0, tx_space};
				default: s_nxt.rdata = 32'h0;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= '0;
			s_r.rx_hwm_prev <= 1'b0;
			s_r.tx_lwm_prev <= 1'b1;
			s_r.tx_empty_prev <= 1'b1;
			s_r.rx_mask <= `HFS_MASK_RESET;
			s_r.tx_mask <= `HFS_MASK_RESET;
			s_r.irq_n <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign hrdata = s_r.rdata;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign rx_packet_bytes_available = pba;
	assign tx_fifo_space_count = {1'b0, tx_space};
	assign irq_out_n = s_r.irq_n;

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_b);

	chk_count_range:
	assert property (pba[6:0] <= `HFS_DEPTH)
		else $error("Receive count above the FIFO depth.");

	chk_count_bound:
	assert property (pba[6:0] <= s_r.rx_lvl)
		else $error("Receive count exceeds the stored bytes.");

	chk_open_msb:
	assert property (pba[7] |-> pba[6:0] == s_r.rx_lvl && s_r.rx_lvl != 0)
		else $error("Open-message bit set with a message end counted.");

	chk_latch_hold:
	assert property (s_r.rx_lat[`HFS_RX_OVR_BIT] && !wr_en
		|=> s_r.rx_lat[`HFS_RX_OVR_BIT])
		else $error("Latched overrun bit dropped without a clear.");

	chk_no_reassert:
	assert property (!s_r.rx_lat[`HFS_RX_HWM_BIT]
		&& !(rx_hwm && !s_r.rx_hwm_prev) |=> !s_r.rx_lat[`HFS_RX_HWM_BIT])
		else $error("Latched watermark bit set without a fresh edge.");

	chk_zero_keeps:
	assert property (wr_en && s_r.ph_idx == `HFS_IDX_TX_LAT
		&& s_r.tx_lat[`HFS_TX_LWM_BIT] && !wbyte[`HFS_TX_LWM_BIT]
		|=> s_r.tx_lat[`HFS_TX_LWM_BIT])
		else $error("Status bit written as zero was cleared.");

	chk_rt_read:
	assert property (acc && !hwrite && haddr[11:2] == `HFS_IDX_RX_RT
		|=> hrdata[`HFS_RX_HWM_BIT] == $past(rx_hwm))
		else $error("Real-time watermark bit does not follow the level.");

	chk_irq_low:
	assert property (!wr_en && |(s_r.rx_lat & s_r.rx_mask) |=> !irq_out_n)
		else $error("Interrupt high with an enabled event pending.");

	chk_mask_gate:
	assert property ((s_r.rx_mask == 8'h00 && s_r.tx_mask == 8'h00) [*2]
		|-> irq_out_n)
		else $error("Interrupt low with all events masked.");

	chk_overrun_drop:
	assert property (rx_ovr_ev |=> s_r.rx_lvl == 0 && s_r.rx_ovr_rt
		&& s_r.rx_lat[`HFS_RX_OVR_BIT])
		else $error("Overrun did not empty the FIFO and flag it.");

	chk_space_read:
	assert property (acc && !hwrite && haddr[11:2] == `HFS_IDX_TX_SPACE
		|=> hrdata == 32'(`HFS_DEPTH - $past(s_r.tx_lvl)))
		else $error("Transmit space read differs from the sampled level.");

	chk_irq_tx_low:
	assert property (!wr_en && |(s_r.tx_lat & s_r.tx_mask)
		|=> !irq_out_n)
		else $error("Interrupt high with an enabled transmit event.");

	chk_irq_cause:
	assert property (!irq_out_n |-> |(s_r.rx_lat & $past(s_r.rx_mask))
		|| |(s_r.tx_lat & $past(s_r.tx_mask)))
		else $error("Interrupt low with no enabled event.");

	chk_eom_set:
	assert property (ev.rx_push && ev.rx_eom && !s_r.rx_drop && !rx_ovr_ev
		|=> s_r.rx_lat[`HFS_RX_EOM_BIT])
		else $error("Message end did not latch its status bit.");

	chk_tx_latch_hold:
	assert property (s_r.tx_lat[`HFS_TX_EMPTY_BIT] && !wr_en
		|=> s_r.tx_lat[`HFS_TX_EMPTY_BIT])
		else $error("Latched empty bit dropped without a clear.");

	chk_tx_no_reassert:
	assert property (!s_r.tx_lat[`HFS_TX_LWM_BIT]
		&& !(tx_lwm && !s_r.tx_lwm_prev) |=> !s_r.tx_lat[`HFS_TX_LWM_BIT])
		else $error("Latched low-level bit set without a fresh edge.");

	chk_rt_write:
	assert property (wr_en && !ev.rx_push
		|=> $stable(s_r.rx_ovr_rt))
		else $error("Real-time overrun bit moved on a register write.");

	chk_one_clears:
	assert property (wr_en && (s_r.ph_idx == `HFS_IDX_RX_LAT
		|| s_r.ph_idx == `HFS_IDX_RX_CLR) && wbyte[`HFS_RX_EOM_BIT]
		&& !(ev.rx_push && ev.rx_eom) |=> !s_r.rx_lat[`HFS_RX_EOM_BIT])
		else $error("Status bit written as one was not cleared.");

	chk_space_sum:
	assert property (tx_fifo_space_count + {1'b0, s_r.tx_lvl}
		== {1'b0, `HFS_DEPTH})
		else $error("Transmit space and level do not add up to the depth.");

	chk_tx_full_refuse:
	assert property (ev.tx_push && !ev.tx_pop && s_r.tx_lvl == `HFS_DEPTH
		|=> s_r.tx_lvl == `HFS_DEPTH)
		else $error("Transmit level moved past the depth.");

	chk_rx_depth:
	assert property (s_r.rx_lvl <= `HFS_DEPTH)
		else $error("Receive level above the FIFO depth.");

	chk_data_stable:
	assert property (!(acc && !hwrite)
		|=> $stable(hrdata))
		else $error("Read data changed without a new read.");

	chk_drop_quiet:
	assert property (s_r.rx_drop && ev.rx_push && !ev.rx_pop
		|=> $stable(s_r.rx_lvl))
		else $error("Byte of a dropped packet entered the FIFO.");

	chk_empty_zero:
	assert property (s_r.rx_lvl == 7'h00
		|-> pba == 8'h00)
		else $error("Receive count not zero with an empty FIFO.");
endmodule

// ==== dv/hfs_host.sv ====
`timescale 1ns/1ps
module hfs_host (
	input wire logic sys_clk,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	output logic hsel,
	output logic [11:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata
);
	initial begin
		hsel = 1'b0;
		haddr = 12'h000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end

	// One single word transfer; write data is driven as given in the data phase.
	task automatic xfer(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		do @(posedge sys_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hready !== 1'b1);
		q = hrdata;
	endtask
endmodule

// ==== dv/hfs_status_bench.sv ====
`timescale 1ns/1ps
`include "hfs_consts.svh"
module hfs_status_bench;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic hsel, hwrite, hreadyout, hresp, irq_out_n;
	logic [11:0] haddr;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [31:0] hwdata, hrdata, q;
	logic [7:0] rx_cnt, tx_cnt;
	hfs_pkg::hfs_ev_t ev = '0;
	int err_total = 0;
	int n_compared = 0;

	always #5 sys_clk = ~sys_clk;

	hfs_status dut (.sys_clk(sys_clk), .rst_b(rst_b), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .ev(ev),
		.rx_packet_bytes_available(rx_cnt), .tx_fifo_space_count(tx_cnt),
		.irq_out_n(irq_out_n));
	hfs_host u_host (.sys_clk(sys_clk), .hready(hreadyout),
		.hrdata(hrdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

	task automatic test_done;
		$display("compared %0d errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_out(input logic [7:0] rx, input logic [7:0] tx,
		input logic irq);
		@(negedge sys_clk);
		chk("rx_count", {24'h0, rx}, {24'h0, rx_cnt});
		chk("tx_space", {24'h0, tx}, {24'h0, tx_cnt});
		chk("irq_out_n", {31'h0, irq}, {31'h0, irq_out_n});
		chk("hresp", 32'h0, {31'h0, hresp});
		@(posedge sys_clk);
	endtask

	task automatic pulse(input logic [4:0] v, input int n);
		repeat (n) begin
			ev <= v;
			@(posedge sys_clk);
		end
		ev <= '0;
		@(posedge sys_clk);
	endtask

	task automatic rd(input logic [9:0] i, output logic [31:0] d);
		u_host.xfer(1'b0, {i, 2'b00}, 32'h0, d);
	endtask

	task automatic wr(input logic [9:0] i, input logic [31:0] d);
		u_host.xfer(1'b1, {i, 2'b00}, d, q);
	endtask

	task automatic t_reset;
		chk_out(8'h00, 8'h40, 1'b1);
		rd(`HFS_IDX_TX_MASK, q);
		chk("tx_mask", 32'h0, q);
		rd(10'h3ff, q);
		chk("unmapped", 32'h0, q);
	endtask

	task automatic t_rx;
		pulse(5'h10, 3);
		chk_out(8'h83, 8'h40, 1'b1);
		pulse(5'h18, 1);
		pulse(5'h10, 2);
		chk_out(8'h04, 8'h40, 1'b1);
		rd(`HFS_IDX_RX_PBA, q);
		chk("rx_pba_reg", 32'h4, q);
	endtask

	task automatic t_irq;
		rd(`HFS_IDX_RX_LAT, q);
		chk("rx_lat", 32'h1, q);
		wr(`HFS_IDX_RX_MASK, 32'h1);
		@(posedge sys_clk);
		chk_out(8'h04, 8'h40, 1'b0);
		wr(`HFS_IDX_RX_LAT, 32'hfe);
		chk_out(8'h04, 8'h40, 1'b0);
		wr(`HFS_IDX_RX_LAT, 32'h01);
		@(posedge sys_clk);
		chk_out(8'h04, 8'h40, 1'b1);
		rd(`HFS_IDX_RX_LAT, q);
		chk("rx_lat_clr", 32'h0, q);
		wr(`HFS_IDX_RX_MASK, 32'h0);
		pulse(5'h18, 1);
		chk_out(8'h04, 8'h40, 1'b1);
		wr(`HFS_IDX_RX_RT, 32'hff);
		rd(`HFS_IDX_RX_RT, q);
		chk("rx_rt", 32'h1, q);
	endtask

	task automatic t_ovr;
		pulse(5'h04, 7);
		pulse(5'h10, 64);
		chk_out(8'hc0, 8'h40, 1'b1);
		pulse(5'h10, 1);
		chk_out(8'h00, 8'h40, 1'b1);
		rd(`HFS_IDX_RX_RT, q);
		chk("rx_rt_ovr", 32'h20, q);
		rd(`HFS_IDX_RX_LAT, q);
		chk("rx_lat_ovr", 32'h20, q & 32'h20);
		pulse(5'h10, 2);
		pulse(5'h18, 1);
		chk_out(8'h00, 8'h40, 1'b1);
		pulse(5'h10, 1);
		chk_out(8'h81, 8'h40, 1'b1);
		pulse(5'h04, 1);
	endtask

	task automatic t_tx;
		pulse(5'h02, 65);
		chk_out(8'h00, 8'h00, 1'b1);
		pulse(5'h01, 10);
		fork
			rd(`HFS_IDX_TX_SPACE, q);
			pulse(5'h02, 1);
		join
		chk("tx_space_reg", 32'ha, q);
		chk_out(8'h00, 8'h09, 1'b1);
		pulse(5'h01, 64);
		rd(`HFS_IDX_TX_LAT, q);
		chk("tx_lat", 32'h3, q);
		wr(`HFS_IDX_TX_MASK, 32'h2);
		@(posedge sys_clk);
		chk_out(8'h00, 8'h40, 1'b0);
		wr(`HFS_IDX_TX_CLR, 32'h3);
		@(posedge sys_clk);
		chk_out(8'h00, 8'h40, 1'b1);
		rd(`HFS_IDX_TX_LAT, q);
		chk("tx_lat_clr", 32'h0, q);
	endtask

	initial begin
		repeat (20) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		t_reset;
		t_rx;
		t_irq;
		t_ovr;
		t_tx;
		test_done;
	end

	initial begin
		repeat (5000) @(posedge sys_clk);
		err_total++;
		test_done;
	end
endmodule
